// ---- asc_regs.svh ----
// Timing counts and fixed codes for the active/standby changeover controller
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_CLK_HZ 40000000
`define ASC_FLASH_MS 250
`define ASC_FLASH_CYC ((`ASC_CLK_HZ / 1000) * `ASC_FLASH_MS)
`define ASC_SLOT_PRIMARY 1'b0
`define ASC_SLOT_SECONDARY 1'b1
`endif

// ---- asc_pkg.sv ----
// Types shared by the active/standby changeover controller
package asc_pkg;
  typedef enum logic [10:0] {
    ASC_ST_INIT     = 11'b000_0000_0001,
    ASC_ST_ADMIT    = 11'b000_0000_0010,
    ASC_ST_RUN      = 11'b000_0000_0100,
    ASC_ST_POLL     = 11'b000_0000_1000,
    ASC_ST_VERIFY   = 11'b000_0001_0000,
    ASC_ST_COPY     = 11'b000_0010_0000,
    ASC_ST_HOLD     = 11'b000_0100_0000,
    ASC_ST_XFER     = 11'b000_1000_0000,
    ASC_ST_SWAP     = 11'b001_0000_0000,
    ASC_ST_TEST     = 11'b010_0000_0000,
    ASC_ST_NONE     = 11'b100_0000_0000
  } asc_state_type;

  typedef enum logic [1:0] {
    ASC_MODE_OFF     = 2'b00,
    ASC_MODE_STANDBY = 2'b01,
    ASC_MODE_ACTIVE  = 2'b10,
    ASC_MODE_HOLD    = 2'b11
  } asc_mode_type;
endpackage

// ---- asc_flasher.sv ----
// Enable-gated flash generator for the education indicator; count and phase clear while disabled
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_flasher #(
  parameter int unsigned HALF_CYC = `ASC_FLASH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  output logic o_flash
);
  typedef struct packed {
    logic [31:0] cnt;
    logic ph;
  } asc_flash_type;

  asc_flash_type st_r;
  asc_flash_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (!i_en)
    begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.ph = 1'b0;
    end
    else if (st_r.cnt >= HALF_CYC - 1)
    begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.ph = ~st_r.ph;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_flash = st_r.ph;
endmodule

// ---- asc_ctrl.sv ----
// Active/standby changeover controller for a redundant module pair
// Summary of operation
// - Secondary slot position is learnt automatically once primary is fitted and operable.
// - At start-up a fitted primary becomes active by default.
// - No primary, configured unique secondary: secondary becomes active at start-up.
// - No primary, shared secondary location: pair is left with no active module.
// - Module goes active at start-up or changeover only with correct type and both removal switches closed; a rollback reactivates the held module unchecked.
// - Active module reports faults; controller then starts a changeover attempt.
// - Changeover polls for a fitted standby, keeping active module meanwhile.
// - Standby checked for type, closed switches and, until secondary position is learnt, pair membership via spare link.
// - Standby loaded with active configuration copy, then placed in standby state.
// - Active module moved to hold state; changeover data then transferred.
// - Education indicator flashes amber during changeover data transfer.
// - After transfer the former standby is active and the original is standby.
// - If new active fails self-test and changeover is not forced, it goes standby and held module reactivates.
// - Both removal switches open on active module counts as a changeover request.
// - Normally a changeover completes only when the incoming module is fault free.
// - Switches open plus reset button forces changeover onto a faulted module.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_ctrl #(
  parameter int unsigned FLASH_CYC = `ASC_FLASH_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Slot 0 is the primary slot, slot 1 the secondary slot
  input wire logic [1:0] i_fitted,
  input wire logic [1:0] i_type_ok,
  input wire logic [1:0] i_sw_a_closed,
  input wire logic [1:0] i_sw_b_closed,
  input wire logic [1:0] i_fault,
  input wire logic [1:0] i_operable,
  input wire logic i_sec_configured,
  input wire logic i_sec_unique,
  input wire logic i_pair_link_ok,
  input wire logic i_reset_button,
  input wire logic i_cfg_done,
  input wire logic i_xfer_done,
  input wire logic i_test_done,
  input wire logic i_test_pass,
  output asc_pkg::asc_mode_type o_mode_pri,
  output asc_pkg::asc_mode_type o_mode_sec,
  output logic o_cfg_start,
  output logic o_cfg_copy,
  output logic [0:0] o_cfg_slot,
  output logic o_xfer_start,
  output logic o_test_start,
  output logic o_sec_known,
  output logic o_active_valid,
  output logic [0:0] o_active_slot,
  output logic o_busy,
  output logic o_request_pending,
  output logic o_forced,
  output logic o_rollback,
  output logic o_edu_amber_flash,
  output asc_pkg::asc_state_type o_state
);
  import asc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    asc_state_type st;
    logic act;
    logic act_valid;
    logic sec_known;
    logic req;
    logic forced;
    logic rollback;
    logic cfg_start;
    logic cfg_copy;
    logic cfg_slot;
    logic xfer_start;
    logic test_start;
    logic cfg_wait;
    asc_mode_type mode0;
    asc_mode_type mode1;
  } asc_ctrl_type;

  asc_ctrl_type s_r;
  asc_ctrl_type s_nxt;

  function automatic logic admit_ok(input logic [1:0] fit, input logic [1:0] typ,
                                    input logic [1:0] swa, input logic [1:0] swb,
                                    input logic idx);
    admit_ok = fit[idx] && typ[idx] && swa[idx] && swb[idx];
  endfunction

  function automatic logic other(input logic idx);
    other = ~idx;
  endfunction

  function automatic asc_mode_type mode_of(input asc_ctrl_type s, input logic idx);
    mode_of = idx ? s.mode1 : s.mode0;
  endfunction

  function automatic asc_ctrl_type set_mode(input asc_ctrl_type s, input logic idx,
                                            input asc_mode_type m);
    asc_ctrl_type t;
    t = s;
    if (idx)
    begin
      t.mode1 = m;
    end
    else
    begin
      t.mode0 = m;
    end
    set_mode = t;
  endfunction

  logic act_sw_open;
  logic act_fault;
  logic sby;
  logic stby_ok;
  logic stby_clean;

  always_comb
  begin
    sby = other(s_r.act);
    act_sw_open = i_fitted[s_r.act] && !i_sw_a_closed[s_r.act] && !i_sw_b_closed[s_r.act];
    act_fault = i_fault[s_r.act];
    stby_ok = admit_ok(i_fitted, i_type_ok, i_sw_a_closed, i_sw_b_closed, sby)
              && (s_r.sec_known || i_pair_link_ok);
    stby_clean = !i_fault[sby] || s_r.forced;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisory sequence

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cfg_start = 1'b0;
    s_nxt.xfer_start = 1'b0;
    s_nxt.test_start = 1'b0;
    s_nxt.rollback = 1'b0;
    // Secondary position known once primary is fitted and operable
    if (i_fitted[0] && i_operable[0])
    begin
      s_nxt.sec_known = 1'b1;
    end
    // Request latch; duplicates while busy fold into the held one
    if (s_r.act_valid && (act_fault || act_sw_open) && !s_r.req)
    begin
      s_nxt.req = 1'b1;
    end
    if (s_r.req && act_sw_open && i_reset_button)
    begin
      s_nxt.forced = 1'b1;
    end
    case (s_r.st)
      ASC_ST_INIT:
      begin
        if (i_fitted[0])
        begin
          s_nxt.act = `ASC_SLOT_PRIMARY;
          s_nxt.st = ASC_ST_ADMIT;
        end
        else if (i_fitted[1] && i_sec_configured && i_sec_unique)
        begin
          s_nxt.act = `ASC_SLOT_SECONDARY;
          s_nxt.st = ASC_ST_ADMIT;
        end
        else if (i_fitted[1] && !i_sec_unique)
        begin
          s_nxt.st = ASC_ST_NONE;
        end
      end
      ASC_ST_ADMIT:
      begin
        if (!s_r.cfg_wait)
        begin
          if (admit_ok(i_fitted, i_type_ok, i_sw_a_closed, i_sw_b_closed, s_r.act))
          begin
            s_nxt.cfg_start = 1'b1;
            s_nxt.cfg_copy = 1'b0;
            s_nxt.cfg_slot = s_r.act;
            s_nxt.cfg_wait = 1'b1;
          end
        end
        else if (i_cfg_done)
        begin
          s_nxt.cfg_wait = 1'b0;
          s_nxt = set_mode(s_nxt, s_r.act, ASC_MODE_ACTIVE);
          s_nxt.act_valid = 1'b1;
          s_nxt.st = ASC_ST_RUN;
        end
      end
      ASC_ST_NONE:
      begin
        s_nxt.act_valid = 1'b0;
      end
      ASC_ST_RUN:
      begin
        if (s_r.req)
        begin
          s_nxt.st = ASC_ST_POLL;
        end
      end
      ASC_ST_POLL:
      begin
        // Active module stays in service while polling
        if (i_fitted[sby])
        begin
          s_nxt.st = ASC_ST_VERIFY;
        end
      end
      ASC_ST_VERIFY:
      begin
        if (stby_ok)
        begin
          s_nxt.cfg_start = 1'b1;
          s_nxt.cfg_copy = 1'b1;
          s_nxt.cfg_slot = sby;
          s_nxt.st = ASC_ST_COPY;
        end
        else if (!i_fitted[sby])
        begin
          s_nxt.st = ASC_ST_POLL;
        end
      end
      ASC_ST_COPY:
      begin
        if (i_cfg_done)
        begin
          s_nxt = set_mode(s_nxt, sby, ASC_MODE_STANDBY);
          s_nxt.st = ASC_ST_HOLD;
        end
      end
      ASC_ST_HOLD:
      begin
        // Incoming module must be clean unless forced
        if (stby_clean)
        begin
          s_nxt = set_mode(s_nxt, s_r.act, ASC_MODE_HOLD);
          s_nxt.xfer_start = 1'b1;
          s_nxt.st = ASC_ST_XFER;
        end
      end
      ASC_ST_XFER:
      begin
        if (i_xfer_done)
        begin
          s_nxt.st = ASC_ST_SWAP;
        end
      end
      ASC_ST_SWAP:
      begin
        s_nxt = set_mode(s_nxt, sby, ASC_MODE_ACTIVE);
        s_nxt.test_start = 1'b1;
        s_nxt.st = ASC_ST_TEST;
      end
      ASC_ST_TEST:
      begin
        if (i_test_done)
        begin
          if (i_test_pass || s_r.forced)
          begin
            s_nxt = set_mode(s_nxt, s_r.act, ASC_MODE_STANDBY);
            s_nxt.act = sby;
          end
          else
          begin
            s_nxt = set_mode(s_nxt, sby, ASC_MODE_STANDBY);
            s_nxt = set_mode(s_nxt, s_r.act, ASC_MODE_ACTIVE);
            s_nxt.rollback = 1'b1;
          end
          s_nxt.req = 1'b0;
          s_nxt.forced = 1'b0;
          s_nxt.st = ASC_ST_RUN;
        end
      end
      default:
      begin
        s_nxt.st = ASC_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      s_r <= '{st: ASC_ST_INIT, mode0: ASC_MODE_OFF, mode1: ASC_MODE_OFF, default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator and outputs

  logic flash;

  asc_flasher #(
    .HALF_CYC(FLASH_CYC)
  ) u_flasher (
    .i_clk(i_clk),
    .i_rst_n(rst_n_r),
    .i_en(s_r.st == ASC_ST_XFER),
    .o_flash(flash)
  );

  assign o_edu_amber_flash = flash;
  assign o_mode_pri = s_r.mode0;
  assign o_mode_sec = s_r.mode1;
  assign o_cfg_start = s_r.cfg_start;
  assign o_cfg_copy = s_r.cfg_copy;
  assign o_cfg_slot = s_r.cfg_slot;
  assign o_xfer_start = s_r.xfer_start;
  assign o_test_start = s_r.test_start;
  assign o_sec_known = s_r.sec_known;
  assign o_active_valid = s_r.act_valid;
  assign o_active_slot = s_r.act;
  assign o_busy = (s_r.st != ASC_ST_RUN) && (s_r.st != ASC_ST_NONE) && (s_r.st != ASC_ST_INIT);
  assign o_request_pending = s_r.req;
  assign o_forced = s_r.forced;
  assign o_rollback = s_r.rollback;
  assign o_state = s_r.st;
endmodule

// ---- asc_ctrl_monitor.sv ----
// Assertion checker for the changeover controller ports
`timescale 1ns/1ps
module asc_ctrl_chk
  import asc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_test_done,
  input wire logic i_test_pass,
  input wire logic o_cfg_start,
  input wire logic o_xfer_start,
  input wire logic o_test_start,
  input wire logic o_rollback,
  input wire logic o_edu_amber_flash,
  input wire logic o_active_valid,
  input wire logic o_request_pending,
  input wire asc_pkg::asc_mode_type o_mode_pri,
  input wire asc_pkg::asc_mode_type o_mode_sec,
  input wire asc_pkg::asc_state_type o_state
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_cfg_place;
    o_cfg_start |-> o_state inside {ASC_ST_ADMIT, ASC_ST_COPY};
  endproperty
  a_cfg_place: assert property (p_cfg_place) else $error("config start out of place");
  property p_no_flash;
    (o_state != ASC_ST_XFER && $past(o_state) != ASC_ST_XFER) |-> !o_edu_amber_flash;
  endproperty
  a_no_flash: assert property (p_no_flash) else $error("indicator flashes outside transfer");
  property p_hold_xfer;
    o_xfer_start |-> o_state == ASC_ST_XFER
      && (o_mode_pri == ASC_MODE_HOLD || o_mode_sec == ASC_MODE_HOLD);
  endproperty
  a_hold_xfer: assert property (p_hold_xfer) else $error("transfer without held module");
  property p_rollback;
    o_rollback |-> $past(o_state) == ASC_ST_TEST && o_active_valid
      && ((o_mode_pri == ASC_MODE_ACTIVE) != (o_mode_sec == ASC_MODE_ACTIVE));
  endproperty
  a_rollback: assert property (p_rollback) else $error("bad rollback");
  property p_one_active;
    !(o_mode_pri == ASC_MODE_ACTIVE && o_mode_sec == ASC_MODE_ACTIVE);
  endproperty
  a_one_active: assert property (p_one_active) else $error("two active modules");
  property p_none;
    o_state == ASC_ST_NONE |-> !o_active_valid;
  endproperty
  a_none: assert property (p_none) else $error("active module in none state");
  property p_req_hold;
    o_request_pending && o_state != ASC_ST_TEST |=> o_request_pending;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_test_ok;
    o_state == ASC_ST_TEST && i_test_done && i_test_pass |=> o_state == ASC_ST_RUN && !o_rollback;
  endproperty
  a_test_ok: assert property (p_test_ok) else $error("passed test not finished");
  property p_test_start;
    o_test_start |-> o_state == ASC_ST_TEST && $past(o_state) == ASC_ST_SWAP;
  endproperty
  a_test_start: assert property (p_test_start) else $error("self-test start out of place");
endmodule
bind asc_ctrl asc_ctrl_chk i_asc_ctrl_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_test_done(i_test_done), .i_test_pass(i_test_pass), .o_cfg_start(o_cfg_start),
  .o_xfer_start(o_xfer_start), .o_test_start(o_test_start), .o_rollback(o_rollback),
  .o_edu_amber_flash(o_edu_amber_flash),
  .o_active_valid(o_active_valid), .o_request_pending(o_request_pending),
  .o_mode_pri(o_mode_pri), .o_mode_sec(o_mode_sec), .o_state(o_state));

// ---- asc_pair_model.sv ----
// Behavioural model of the redundant module pair handshakes
`timescale 1ns/1ps
module asc_pair_model (
  input wire logic i_clk,
  input wire logic i_cfg_start,
  input wire logic i_xfer_start,
  input wire logic i_test_start,
  input wire logic i_pass,
  output logic o_cfg_done,
  output logic o_xfer_done,
  output logic o_test_done,
  output logic o_test_pass
);
  initial
  begin
    o_cfg_done = 1'h0;
    o_xfer_done = 1'h0;
    o_test_done = 1'h0;
    o_test_pass = 1'h0;
  end
  always
  begin
    @(posedge i_clk iff i_cfg_start);
    repeat (3) @(posedge i_clk);
    #2 o_cfg_done = 1'h1;
    @(posedge i_clk);
    #2 o_cfg_done = 1'h0;
  end
  // Long transfer so the indicator toggles several times
  always
  begin
    @(posedge i_clk iff i_xfer_start);
    repeat (12) @(posedge i_clk);
    #2 o_xfer_done = 1'h1;
    @(posedge i_clk);
    #2 o_xfer_done = 1'h0;
  end
  // Pass line is only meaningful with done; otherwise shows the inverse
  always
  begin
    @(posedge i_clk iff i_test_start);
    repeat (4) @(posedge i_clk);
    #2 o_test_pass = i_pass;
    o_test_done = 1'h1;
    @(posedge i_clk);
    #2 o_test_done = 1'h0;
    o_test_pass = ~i_pass;
  end
endmodule

// ---- asc_ctrl_tb.sv ----
// Self-checking bench for the changeover controller
`timescale 1ns/1ps
module asc_ctrl_tb;
  import asc_pkg::*;
  logic i_clk, i_arst_n, cfgd, uniq, link, btn, pass, flash_seen;
  logic [1:0] fit, tok, swa, swb, flt, opr;
  logic cfg_done, xfer_done, test_done, test_pass, cfg_start, xfer_start, test_start;
  logic valid, forced, known, rollback, flash, busy, pend, copy;
  logic [0:0] slot, cslot;
  asc_mode_type mp, ms;
  asc_state_type st;
  int bad_count, cmp_count, cycles;
  asc_ctrl #(.FLASH_CYC(4)) i_asc_ctrl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_fitted(fit),
    .i_type_ok(tok), .i_sw_a_closed(swa), .i_sw_b_closed(swb), .i_fault(flt),
    .i_operable(opr), .i_sec_configured(cfgd), .i_sec_unique(uniq), .i_pair_link_ok(link),
    .i_reset_button(btn), .i_cfg_done(cfg_done), .i_xfer_done(xfer_done),
    .i_test_done(test_done), .i_test_pass(test_pass), .o_mode_pri(mp), .o_mode_sec(ms),
    .o_cfg_start(cfg_start), .o_cfg_copy(copy), .o_cfg_slot(cslot), .o_xfer_start(xfer_start),
    .o_test_start(test_start), .o_sec_known(known), .o_active_valid(valid),
    .o_active_slot(slot), .o_busy(busy), .o_request_pending(pend), .o_forced(forced),
    .o_rollback(rollback), .o_edu_amber_flash(flash), .o_state(st));
  asc_pair_model i_asc_pair_model (.i_clk(i_clk), .i_cfg_start(cfg_start),
    .i_xfer_start(xfer_start), .i_test_start(test_start), .i_pass(pass),
    .o_cfg_done(cfg_done), .o_xfer_done(xfer_done), .o_test_done(test_done),
    .o_test_pass(test_pass));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_st(input asc_state_type s);
    int n;
    n = 0;
    while (st !== s && n < 300)
    begin
      cyc(1);
      n++;
    end
    chk(st, s);
  endtask
  task automatic boot(input logic [1:0] f, input logic u);
    i_arst_n = 1'h0;
    fit = f;
    uniq = u;
    cyc(5);
    chk(st, ASC_ST_INIT);
    i_arst_n = 1'h1;
    cyc(6);
  endtask
  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (flash === 1'h1)
      flash_seen = 1'h1;
    if (cycles == 5000)
    begin
      bad_count++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_arst_n = 1'h0;
    fit = 2'h2;
    tok = 2'h3;
    opr = 2'h3;
    swa = 2'h3;
    swb = 2'h3;
    flt = 2'h0;
    cfgd = 1'h1;
    uniq = 1'h0;
    link = 1'h1;
    btn = 1'h0;
    pass = 1'h1;
    flash_seen = 1'h0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    boot(2'h2, 1'h0);
    chk({st, valid}, {ASC_ST_NONE, 1'h0});
    boot(2'h2, 1'h1);
    wait_st(ASC_ST_RUN);
    chk(ms, ASC_MODE_ACTIVE);
    chk(known, 1'h0);
    tok = 2'h2;
    opr = 2'h2;
    boot(2'h1, 1'h1);
    cyc(10);
    chk({valid, known}, 2'h0);
    tok = 2'h3;
    opr = 2'h3;
    wait_st(ASC_ST_RUN);
    chk({mp, slot, known}, {ASC_MODE_ACTIVE, 1'h0, 1'h1});
    chk({busy, pend, copy, cslot}, 4'h0);
    $display("Test start-up done");
    flt = 2'h1;
    wait_st(ASC_ST_POLL);
    cyc(10);
    chk({st, mp}, {ASC_ST_POLL, ASC_MODE_ACTIVE});
    chk({busy, pend}, 2'h3);
    fit = 2'h3;
    wait_st(ASC_ST_HOLD);
    chk(ms, ASC_MODE_STANDBY);
    chk({copy, cslot}, 2'h3);
    wait_st(ASC_ST_XFER);
    chk(mp, ASC_MODE_HOLD);
    flt = 2'h0;
    wait_st(ASC_ST_RUN);
    chk(flash_seen, 1'h1);
    chk({mp, ms, slot}, {ASC_MODE_STANDBY, ASC_MODE_ACTIVE, 1'h1});
    chk(pend, 1'h0);
    $display("Test changeover done");
    pass = 1'h0;
    swa = 2'h1;
    swb = 2'h1;
    wait_st(ASC_ST_TEST);
    wait_st(ASC_ST_RUN);
    swa = 2'h3;
    swb = 2'h3;
    chk({rollback, mp, ms}, {1'h1, ASC_MODE_STANDBY, ASC_MODE_ACTIVE});
    $display("Test rollback done");
    pass = 1'h1;
    flt = 2'h3;
    wait_st(ASC_ST_HOLD);
    cyc(20);
    chk(st, ASC_ST_HOLD);
    swa = 2'h1;
    swb = 2'h1;
    btn = 1'h1;
    cyc(3);
    chk(forced, 1'h1);
    wait_st(ASC_ST_XFER);
    flt = 2'h0;
    btn = 1'h0;
    swa = 2'h3;
    swb = 2'h3;
    wait_st(ASC_ST_RUN);
    chk(mp, ASC_MODE_ACTIVE);
    $display("Test forced changeover done");
    wrap_up;
  end
endmodule
